/* verilog/ccr_pkg.sv */
`default_nettype none
package ccr_pkg;
    // special-function register addresses on the core's register bus
    localparam logic [7:0] CCR_ADDR_CONTROL = 8'h9B;
    localparam logic [7:0] CCR_ADDR_MODE    = 8'h9D;
    localparam logic [7:0] CCR_ADDR_INSEL   = 8'h9F;

    // reset values
    localparam logic [7:0] CCR_RST_CONTROL = 8'h00;
    localparam logic [7:0] CCR_RST_MODE    = 8'h02;
    localparam logic [7:0] CCR_RST_INSEL   = 8'hFF;

    // control register fields
    localparam int CCR_CTL_ON      = 7;
    localparam int CCR_CTL_RESULT  = 6;
    localparam int CCR_CTL_RISE    = 5;
    localparam int CCR_CTL_FALL    = 4;
    localparam int CCR_CTL_HYP_LSB = 2;
    localparam int CCR_CTL_HYN_LSB = 0;

    // mode register fields
    localparam int CCR_MD_RIE     = 5;
    localparam int CCR_MD_FIE     = 4;
    localparam int CCR_MD_SPD_LSB = 0;

    // input select register fields
    localparam int CCR_MX_MINUS_LSB = 4;
    localparam int CCR_MX_PLUS_LSB  = 0;

    // field widths
    localparam int CCR_HYST_W = 2;
    localparam int CCR_SEL_W  = 4;
    localparam int CCR_SPD_W  = 2;

    // top bit of a selection code means no pin connected
    localparam int CCR_SEL_NONE_BIT = 3;

    // one-hot pin enable: eight candidate pins per comparator input
    localparam int CCR_PINS = 8;
endpackage : ccr_pkg
`default_nettype wire

/* verilog/ccr_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser with edge detection on the last two stages
module ccr_edge_sync
    import ccr_pkg::*;
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // asynchronous comparator level
    input  wire logic async_in,
    // synchronised level and edge pulses
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    logic [2:0] sync_q; // stage 0 only feeds stage 1

    // shift chain; an edge is flagged while stages 1 and 2 differ
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], async_in};
        end
    end

    // stage 2 is the settled level, stage 1 the newer sample
    assign level_out = sync_q[2];
    assign rise_out  = sync_q[1] & ~sync_q[2];
    assign fall_out  = ~sync_q[1] & sync_q[2];
endmodule // ccr_edge_sync
`default_nettype wire

/* verilog/ccr_comparator_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module ccr_comparator_regs
    import ccr_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    // special-function register bus
    input  wire logic [7:0]            sfr_addr_in,
    input  wire logic                  sfr_wr_in,
    input  wire logic                  sfr_rd_in,
    input  wire logic [7:0]            sfr_wdata_in,
    output logic      [7:0]            sfr_rdata_out,
    // analog comparator
    input  wire logic                  compare_result_in,
    output logic                       comparator_on_out,
    output logic      [CCR_HYST_W-1:0] hyst_plus_code_out,
    output logic      [CCR_HYST_W-1:0] hyst_minus_code_out,
    output logic      [CCR_SPD_W-1:0]  response_speed_code_out,
    // input multiplexer one-hot pin enables
    output logic      [CCR_PINS-1:0]   plus_input_en_out,
    output logic      [CCR_PINS-1:0]   minus_input_en_out,
    // routed output and interrupt request
    output logic                       compare_pin_out,
    output logic                       irq_out
);
    // register state
    logic                  on_q;         // comparator enable
    logic                  rise_q;       // sticky rising flag
    logic                  fall_q;       // sticky falling flag
    logic [CCR_HYST_W-1:0] hyp_q;        // plus hysteresis
    logic [CCR_HYST_W-1:0] hyn_q;        // minus hysteresis
    logic                  rie_q;        // rising irq enable
    logic                  fie_q;        // falling irq enable
    logic [CCR_SPD_W-1:0]  spd_q;        // response speed
    logic [CCR_SEL_W-1:0]  minus_sel_q;  // minus pin select
    logic [CCR_SEL_W-1:0]  plus_sel_q;   // plus pin select
    logic [7:0]            rdata_d;      // read mux
    logic                  sync_level;   // synchronised result
    logic                  sync_rise;    // rising pulse
    logic                  sync_fall;    // falling pulse
    logic                  wr_ctl;       // control write strobe
    logic                  wr_md;        // mode write strobe
    logic                  wr_mx;        // select write strobe

    // decode a selection code into one-hot pin enables, none if top set
    function automatic logic [CCR_PINS-1:0] sel_decode(
        input logic [CCR_SEL_W-1:0] code
    );
        logic [CCR_PINS-1:0] hot;
        hot = '0;
        if (!code[CCR_SEL_NONE_BIT]) begin
            hot[code[CCR_SEL_NONE_BIT-1:0]] = 1'b1;
        end
        return hot;
    endfunction

    // comparator output crosses into the clock domain first
    ccr_edge_sync u_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .async_in  (compare_result_in),
        .level_out (sync_level),
        .rise_out  (sync_rise),
        .fall_out  (sync_fall)
    );

    // address decode of write strobes
    always_comb begin
        wr_ctl = 1'b0;
        wr_md  = 1'b0;
        wr_mx  = 1'b0;
        if (sfr_wr_in && sfr_addr_in == CCR_ADDR_CONTROL) begin
            wr_ctl = 1'b1;
        end else if (sfr_wr_in && sfr_addr_in == CCR_ADDR_MODE) begin
            wr_md = 1'b1;
        end else if (sfr_wr_in && sfr_addr_in == CCR_ADDR_INSEL) begin
            wr_mx = 1'b1;
        end
    end

    // control register: enable and hysteresis codes
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            on_q  <= CCR_RST_CONTROL[CCR_CTL_ON];
            hyp_q <= CCR_RST_CONTROL[CCR_CTL_HYP_LSB +: CCR_HYST_W];
            hyn_q <= CCR_RST_CONTROL[CCR_CTL_HYN_LSB +: CCR_HYST_W];
        end else if (wr_ctl) begin
            on_q  <= sfr_wdata_in[CCR_CTL_ON];
            hyp_q <= sfr_wdata_in[CCR_CTL_HYP_LSB +: CCR_HYST_W];
            hyn_q <= sfr_wdata_in[CCR_CTL_HYN_LSB +: CCR_HYST_W];
        end
    end

    // sticky edge flags; a new edge wins over a software write of zero
    // edges are only taken while enabled, a powered-down comparator
    // reports nothing meaningful
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rise_q <= CCR_RST_CONTROL[CCR_CTL_RISE];
            fall_q <= CCR_RST_CONTROL[CCR_CTL_FALL];
        end else begin
            if (on_q && sync_rise) begin
                rise_q <= 1'b1;
            end else if (wr_ctl) begin
                rise_q <= sfr_wdata_in[CCR_CTL_RISE];
            end
            if (on_q && sync_fall) begin
                fall_q <= 1'b1;
            end else if (wr_ctl) begin
                fall_q <= sfr_wdata_in[CCR_CTL_FALL];
            end
        end
    end

    // mode register; bits 7-6 and 3-2 have no storage
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rie_q <= CCR_RST_MODE[CCR_MD_RIE];
            fie_q <= CCR_RST_MODE[CCR_MD_FIE];
            spd_q <= CCR_RST_MODE[CCR_MD_SPD_LSB +: CCR_SPD_W];
        end else if (wr_md) begin
            rie_q <= sfr_wdata_in[CCR_MD_RIE];
            fie_q <= sfr_wdata_in[CCR_MD_FIE];
            spd_q <= sfr_wdata_in[CCR_MD_SPD_LSB +: CCR_SPD_W];
        end
    end

    // input select register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            minus_sel_q <= CCR_RST_INSEL[CCR_MX_MINUS_LSB +: CCR_SEL_W];
            plus_sel_q  <= CCR_RST_INSEL[CCR_MX_PLUS_LSB +: CCR_SEL_W];
        end else if (wr_mx) begin
            minus_sel_q <= sfr_wdata_in[CCR_MX_MINUS_LSB +: CCR_SEL_W];
            plus_sel_q  <= sfr_wdata_in[CCR_MX_PLUS_LSB +: CCR_SEL_W];
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        if (sfr_addr_in == CCR_ADDR_CONTROL) begin
            rdata_d[CCR_CTL_ON]     = on_q;
            rdata_d[CCR_CTL_RESULT] = sync_level;
            rdata_d[CCR_CTL_RISE]   = rise_q;
            rdata_d[CCR_CTL_FALL]   = fall_q;
            rdata_d[CCR_CTL_HYP_LSB +: CCR_HYST_W] = hyp_q;
            rdata_d[CCR_CTL_HYN_LSB +: CCR_HYST_W] = hyn_q;
        end else if (sfr_addr_in == CCR_ADDR_MODE) begin
            // upper bits stay zero
            rdata_d[CCR_MD_RIE] = rie_q;
            rdata_d[CCR_MD_FIE] = fie_q;
            rdata_d[CCR_MD_SPD_LSB +: CCR_SPD_W] = spd_q;
        end else if (sfr_addr_in == CCR_ADDR_INSEL) begin
            rdata_d[CCR_MX_MINUS_LSB +: CCR_SEL_W] = minus_sel_q;
            rdata_d[CCR_MX_PLUS_LSB +: CCR_SEL_W]  = plus_sel_q;
        end
    end

    // read data registered; valid the cycle after the read strobe
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_rd_in) begin
            sfr_rdata_out <= rdata_d;
        end
    end

    // analog controls registered so they never glitch
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            comparator_on_out       <= 1'b0;
            hyst_plus_code_out      <= '0;
            hyst_minus_code_out     <= '0;
            response_speed_code_out <= CCR_RST_MODE[CCR_SPD_W-1:0];
            plus_input_en_out       <= '0;
            minus_input_en_out      <= '0;
        end else begin
            comparator_on_out       <= on_q;
            hyst_plus_code_out      <= hyp_q;
            hyst_minus_code_out     <= hyn_q;
            response_speed_code_out <= spd_q;
            plus_input_en_out       <= sel_decode(plus_sel_q);
            minus_input_en_out      <= sel_decode(minus_sel_q);
        end
    end

    // routed output and interrupt request
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            compare_pin_out <= 1'b0;
            irq_out         <= 1'b0;
        end else begin
            compare_pin_out <= on_q & sync_level;
            irq_out <= (rise_q & rie_q) | (fall_q & fie_q);
        end
    end

    // assertions
    property p_pin_low_off;
        @(posedge clk_in) disable iff (!rst_n_in)
        !on_q |=> !compare_pin_out;
    endproperty
    a_pin_low_off: assert property (p_pin_low_off)
        else $error("routed output high while comparator off");

    property p_rise_set;
        @(posedge clk_in) disable iff (!rst_n_in)
        on_q && sync_rise |=> rise_q;
    endproperty
    a_rise_set: assert property (p_rise_set)
        else $error("rising flag not set after rising edge");

    property p_fall_set;
        @(posedge clk_in) disable iff (!rst_n_in)
        on_q && sync_fall |=> fall_q;
    endproperty
    a_fall_set: assert property (p_fall_set)
        else $error("falling flag not set after falling edge");

    property p_rise_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        rise_q && !wr_ctl |=> rise_q;
    endproperty
    a_rise_hold: assert property (p_rise_hold)
        else $error("rising flag dropped without a write");

    property p_mode_top_zero;
        @(posedge clk_in) disable iff (!rst_n_in)
        sfr_rd_in && sfr_addr_in == CCR_ADDR_MODE
            |=> sfr_rdata_out[7:6] == 2'h0;
    endproperty
    a_mode_top_zero: assert property (p_mode_top_zero)
        else $error("mode register top bits read nonzero");

    property p_irq_rise;
        @(posedge clk_in) disable iff (!rst_n_in)
        rise_q && rie_q |=> irq_out;
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("enabled rising flag gave no request");

    property p_irq_fall;
        @(posedge clk_in) disable iff (!rst_n_in)
        fall_q && fie_q |=> irq_out;
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("enabled falling flag gave no request");

    property p_irq_blocked;
        @(posedge clk_in) disable iff (!rst_n_in)
        !(rise_q && rie_q) && !(fall_q && fie_q) |=> !irq_out;
    endproperty
    a_irq_blocked: assert property (p_irq_blocked)
        else $error("request without enabled flag");

    property p_sel_none;
        @(posedge clk_in) disable iff (!rst_n_in)
        plus_sel_q[CCR_SEL_NONE_BIT] && $stable(plus_sel_q)
            |=> plus_input_en_out == '0;
    endproperty
    a_sel_none: assert property (p_sel_none)
        else $error("plus pin connected with none code");

    property p_hyst_follow;
        @(posedge clk_in) disable iff (!rst_n_in)
        wr_ctl |=> ##1 hyst_minus_code_out
            == $past(sfr_wdata_in[CCR_CTL_HYN_LSB +: CCR_HYST_W], 2);
    endproperty
    a_hyst_follow: assert property (p_hyst_follow)
        else $error("minus hysteresis code not passed on");
endmodule // ccr_comparator_regs
`default_nettype wire

/* verification/ccr_comparator_model.sv */
`timescale 1ns/1ps
`default_nettype none
// behavioural analog comparator: hysteresis, response delay, muxed inputs
module ccr_comparator_model (
    // clock used only to pace the response delay
    input  wire logic        clk_in,
    // controls from the register block
    input  wire logic        on_in,
    input  wire logic [1:0]  hyp_in,
    input  wire logic [1:0]  hyn_in,
    input  wire logic [1:0]  spd_in,
    input  wire logic [7:0]  plus_en_in,
    input  wire logic [7:0]  minus_en_in,
    // input voltages in millivolts
    input  wire logic [15:0] plus_mv_in,
    input  wire logic [15:0] minus_mv_in,
    // raw comparator level
    output logic             result_out
);
    logic [15:0] hyst_mv [4] = '{16'h0000, 16'h0005, 16'h000A, 16'h0014};
    logic        target;       // level the output heads for
    logic [2:0]  cnt_q = 3'h0; // cycles spent disagreeing
    initial result_out = 1'b0;
    // unpowered or unconnected inputs leave the output low
    always_comb begin
        if (!on_in || plus_en_in == 8'h00 || minus_en_in == 8'h00) begin
            target = 1'b0;
        end else if (result_out) begin
            target = plus_mv_in + hyst_mv[hyn_in] > minus_mv_in;
        end else begin
            target = plus_mv_in > minus_mv_in + hyst_mv[hyp_in];
        end
    end
    // slower modes wait more cycles; the swing lands off the clock edge
    always @(posedge clk_in) begin
        if (target == result_out) begin
            cnt_q <= 3'h0;
        end else if (cnt_q >= {1'b0, spd_in}) begin
            result_out <= #3 target;
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
endmodule // ccr_comparator_model
`default_nettype wire

/* verification/test_comparator_control_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_comparator_control_regs;
    import ccr_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r;} ccr_row_s;
    logic        clk = 1'b0;   // 100 MHz
    logic        rst_n, wr, rd, cres, on, pin, irq;
    logic [7:0]  addr, wdata, rdata, pen, men;
    logic [1:0]  hyp, hyn, spd;
    logic [15:0] pmv, mmv;     // pin voltages in millivolts
    int          n_fail = 0, comparisons = 0, cycles = 0;
    // write, then expected read-back; unmapped address last
    ccr_row_s rows [7] = '{'{CCR_ADDR_MODE, 8'hFF, 8'h33},
        '{CCR_ADDR_MODE, 8'h00, 8'h00}, '{CCR_ADDR_MODE, 8'h21, 8'h21},
        '{CCR_ADDR_MODE, 8'h12, 8'h12}, '{CCR_ADDR_CONTROL, 8'h0F, 8'h0F},
        '{CCR_ADDR_CONTROL, 8'h46, 8'h06}, '{8'h9C, 8'h55, 8'h00}};
    ccr_comparator_regs dut_u (.clk_in(clk), .rst_n_in(rst_n),
        .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd),
        .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
        .compare_result_in(cres), .comparator_on_out(on),
        .hyst_plus_code_out(hyp), .hyst_minus_code_out(hyn),
        .response_speed_code_out(spd), .plus_input_en_out(pen),
        .minus_input_en_out(men), .compare_pin_out(pin), .irq_out(irq));
    ccr_comparator_model model_u (.clk_in(clk), .on_in(on), .hyp_in(hyp),
        .hyn_in(hyn), .spd_in(spd), .plus_en_in(pen), .minus_en_in(men),
        .plus_mv_in(pmv), .minus_mv_in(mmv), .result_out(cres));
    initial forever #5 clk = ~clk;
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe, driven on the falling edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // read data is registered, so it is looked at one edge later
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, exp);
    endtask
    // bounded wait for the request level, then compare it
    task automatic wait_irq(input logic exp);
        for (int i = 0; i < 20 && irq !== exp; i++) @(negedge clk);
        chk({7'h00, irq}, {7'h00, exp});
    endtask
    function automatic logic [7:0] sel(input logic [3:0] k);
        return k[3] ? 8'h00 : 8'h01 << k[2:0];
    endfunction
    initial begin
        {rst_n, wr, rd, addr, wdata} = '0;
        pmv = 16'h03E8;
        mmv = 16'h0400;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].r);
            if (rows[i].a == CCR_ADDR_CONTROL) begin
                chk({4'h0, hyp, hyn}, rows[i].r & 8'h0F);
            end
            if (rows[i].a == CCR_ADDR_MODE) begin
                chk({6'h00, spd}, rows[i].r & 8'h03);
            end
        end
        $display("test register rows finished");
        for (int c = 0; c < 16; c++) begin
            wr_reg(CCR_ADDR_INSEL, {c[3:0], ~c[3:0]});
            rd_chk(CCR_ADDR_INSEL, {c[3:0], ~c[3:0]});
            @(negedge clk);
            chk(pen, sel(~c[3:0]));
            chk(men, sel(c[3:0]));
        end
        $display("test input select finished");
        // power up, let it settle, then clear any false edges
        wr_reg(CCR_ADDR_INSEL, 8'h00);
        wr_reg(CCR_ADDR_CONTROL, 8'h80);
        wr_reg(CCR_ADDR_MODE, 8'h30);
        repeat (8) @(negedge clk);
        wr_reg(CCR_ADDR_CONTROL, 8'h80);
        rd_chk(CCR_ADDR_CONTROL, 8'h80);
        chk({7'h00, on}, 8'h01);
        pmv = 16'h0500;
        wait_irq(1'b1);
        rd_chk(CCR_ADDR_CONTROL, 8'hE0);
        chk({7'h00, pin}, 8'h01);
        wr_reg(CCR_ADDR_CONTROL, 8'h80);
        rd_chk(CCR_ADDR_CONTROL, 8'hC0);
        wait_irq(1'b0);
        wr_reg(CCR_ADDR_MODE, 8'h10);
        pmv = 16'h0300;
        wait_irq(1'b1);
        rd_chk(CCR_ADDR_CONTROL, 8'h90);
        wr_reg(CCR_ADDR_MODE, 8'h20);
        wait_irq(1'b0);
        pmv = 16'h0500;
        wait_irq(1'b1);
        wr_reg(CCR_ADDR_CONTROL, 8'h00);
        repeat (4) @(negedge clk);
        chk({6'h00, pin, irq}, 8'h00);
        rd_chk(CCR_ADDR_CONTROL, 8'h00);
        $display("test edge flags finished");
        // reset in mid-run restores every register
        wr_reg(CCR_ADDR_CONTROL, 8'h8F);
        wr_reg(CCR_ADDR_INSEL, 8'h12);
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(CCR_ADDR_CONTROL, 8'h00);
        rd_chk(CCR_ADDR_MODE, 8'h02);
        rd_chk(CCR_ADDR_INSEL, 8'hFF);
        chk({on, spd, 5'h00}, 8'h40);
        chk(pen | men, 8'h00);
        $display("test reset finished");
        give_verdict();
    end
endmodule // test_comparator_control_regs
`default_nettype wire
